// ==== common/sleepy_pkg.sv ====
// shared constants and state types for the sleepy child timeout block
// assumes a 10 MHz system clock feeding all users of this package
package sleepy_pkg;
    // clock and time units
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned MS_NS          = 1_000_000;
    localparam int unsigned MS_CYCLES      = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MS_PER_SP_UNIT = 10;
    // packet buffering timeout, in sleep period units
    localparam logic [18:0] BUF_NUM = 19'h00006;
    localparam logic [18:0] BUF_DEN = 19'h00005;
    localparam logic [11:0] BUF_MIN = 12'h078;
    localparam logic [11:0] BUF_MAX = 12'hbb8;
    // child poll timeout, in sleep period units
    localparam logic [33:0] POLL_MULT = 34'h000000003;
    localparam logic [33:0] POLL_MIN  = 34'h0000001f4;
    // acknowledgement timeout, in ms
    localparam logic [23:0] ACK_HOP_MS = 24'h000032;
    localparam logic [23:0] ACK_SP_MS  = 24'h00000c;
    localparam logic [23:0] ACK_MULT   = 24'h000003;
    localparam logic [1:0]  MAX_TRIES  = 2'h3;
    // sleep mode and line configuration codes
    localparam logic [2:0] SLEEP_CYCLIC     = 3'h4;
    localparam logic [2:0] SLEEP_CYCLIC_PIN = 3'h5;
    localparam logic [2:0] LINE_ADC         = 3'h2;
    localparam logic [2:0] LINE_DIN         = 3'h3;
    localparam logic [2:0] LINE_DOUT_LO     = 3'h4;
    localparam logic [2:0] LINE_DOUT_HI     = 3'h5;
    localparam int unsigned ADC_LINES       = 4;

    typedef enum logic [1:0] {TX_IDLE, TX_WAIT} tx_state_e;
    typedef enum logic [1:0] {DEV_OFF, DEV_SLEEP, DEV_AWAKE} dev_state_e;
endpackage

// ==== rtl/tick_div.sv ====
// tick divider: one-cycle tick every DIV steps
// assumes step is a one-cycle strobe on the same clock
`timescale 1ns/1ps
module tick_div #(
    parameter int unsigned DIV = 10
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // step in, tick out
    input  wire logic step,
    output logic      tick
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (step) begin
            if (cnt_q == LAST) begin
                cnt_d  = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + W'(1);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= tick_d;
        end
    end
endmodule

// ==== rtl/sleepy_child_timeouts.sv ====
// parent-side child timeouts, ack retry timing and end-device sleep cadence
// assumes settings are static between events and strobes are one-cycle pulses
// Function
// - hold a child's packet until it polls or its buffer timer expires
// - buffering timeout is 1.2 times sleep period, clamped 1.2 s to 30 s
// - each child keeps its own last-poll timer, refreshed on every poll
// - poll timeout is 3 times period times cycle count, at least 5 s
// - child silent past poll timeout loses its held packet
// - ack timeout to a router depends only on max unicast hops
// - ack timeout to end device is 3*(50*hops + 1.2*period)
// - on ack timeout retransmit, at most two more, stop on ack
// - sleep period counts 10 ms units
// - wake time and sample interval count 1 ms units
// - indication every N sleep cycles, and whenever radio data arrives while sleep select is cyclic (4 or 5)
// - emit one sample per interval while awake, then sleep
// - sleep select 4 is cyclic, 5 is cyclic with pin wake
// - sampling only when some line is enabled for sampling
// - line code 3 is a digital input that is sampled
`timescale 1ns/1ps
module sleepy_child_timeouts #(
    parameter int unsigned NUM_CHILDREN = 4,
    parameter int unsigned NUM_LINES    = 15,
    parameter int unsigned MS_CYCLES    = sleepy_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // settings
    input  wire logic [15:0]                   sleep_period,
    input  wire logic [15:0]                   sleep_cycle_count,
    input  wire logic [7:0]                    max_unicast_hops,
    input  wire logic [15:0]                   wake_time,
    input  wire logic [15:0]                   sample_interval,
    input  wire logic [2:0]                    sleep_select,
    input  wire logic [3*NUM_LINES-1:0]        line_config,
    // parent: packet and poll events
    input  wire logic                          pkt_arrive,
    input  wire logic [$clog2(NUM_CHILDREN)-1:0] pkt_child,
    input  wire logic                          poll_req,
    input  wire logic [$clog2(NUM_CHILDREN)-1:0] poll_child,
    output logic      [NUM_CHILDREN-1:0]       held,
    output logic      [NUM_CHILDREN-1:0]       child_alive,
    output logic      [NUM_CHILDREN-1:0]       pkt_release,
    output logic      [NUM_CHILDREN-1:0]       pkt_drop,
    // unicast acknowledgement timing
    input  wire logic                          tx_start,
    input  wire logic                          tx_to_end_device,
    input  wire logic                          ack_rcvd,
    output logic                               tx_busy,
    output logic                               tx_send,
    output logic                               tx_done,
    output logic                               tx_fail,
    // end-device sleep side
    input  wire logic                          pin_wake_n,
    input  wire logic                          rf_data_rx,
    output logic                               dev_awake,
    output logic                               on_indicator,
    output logic                               sample_strobe
);
    localparam int unsigned CW = $clog2(NUM_CHILDREN);

    ////////////////////////////////////////////////////////////////////////
    // time bases
    logic ms_tick;
    logic tick10;

    tick_div #(.DIV(MS_CYCLES)) u_ms (
        .clock (clock),
        .rst   (rst),
        .step  (1'b1),
        .tick  (ms_tick)
    );

    tick_div #(.DIV(sleepy_pkg::MS_PER_SP_UNIT)) u_sp (
        .clock (clock),
        .rst   (rst),
        .step  (ms_tick),
        .tick  (tick10)
    );

    ////////////////////////////////////////////////////////////////////////
    // timeout arithmetic
    logic [18:0] buf_raw;
    logic [11:0] buf_calc;
    logic [33:0] poll_raw;
    logic [33:0] poll_calc;
    logic [23:0] ack_calc;

    always_comb begin
        buf_raw = (19'(sleep_period) * sleepy_pkg::BUF_NUM) / sleepy_pkg::BUF_DEN;
        if (buf_raw < 19'(sleepy_pkg::BUF_MIN)) begin
            buf_calc = sleepy_pkg::BUF_MIN;
        end else if (buf_raw > 19'(sleepy_pkg::BUF_MAX)) begin
            buf_calc = sleepy_pkg::BUF_MAX;
        end else begin
            buf_calc = buf_raw[11:0];
        end
        poll_raw  = sleepy_pkg::POLL_MULT * 34'(sleep_period) * 34'(sleep_cycle_count);
        poll_calc = (poll_raw < sleepy_pkg::POLL_MIN) ? sleepy_pkg::POLL_MIN : poll_raw;
        ack_calc = sleepy_pkg::ACK_HOP_MS * 24'(max_unicast_hops);
        if (tx_to_end_device) begin
            ack_calc = sleepy_pkg::ACK_MULT
                     * (ack_calc + sleepy_pkg::ACK_SP_MS * 24'(sleep_period));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-child hold and timers
    logic [11:0]             buf_t_q   [NUM_CHILDREN];
    logic [11:0]             buf_t_d   [NUM_CHILDREN];
    logic [11:0]             buf_lim_q [NUM_CHILDREN];
    logic [11:0]             buf_lim_d [NUM_CHILDREN];
    logic [33:0]             poll_t_q  [NUM_CHILDREN];
    logic [33:0]             poll_t_d  [NUM_CHILDREN];
    logic [NUM_CHILDREN-1:0] held_q;
    logic [NUM_CHILDREN-1:0] held_d;
    logic [NUM_CHILDREN-1:0] rel_d;
    logic [NUM_CHILDREN-1:0] drop_d;

    always_comb begin
        for (int i = 0; i < NUM_CHILDREN; i++) begin
            held_d[i]    = held_q[i];
            buf_t_d[i]   = buf_t_q[i];
            buf_lim_d[i] = buf_lim_q[i];
            poll_t_d[i]  = poll_t_q[i];
            rel_d[i]     = 1'b0;
            drop_d[i]    = 1'b0;
            if (tick10 && buf_t_q[i] != '0) begin
                buf_t_d[i] = buf_t_q[i] - 12'h001;
            end
            if (tick10 && poll_t_q[i] != '0) begin
                poll_t_d[i] = poll_t_q[i] - 34'h000000001;
            end
            if (held_q[i] && tick10 && buf_t_q[i] == 12'h001) begin
                held_d[i] = 1'b0;
                drop_d[i] = 1'b1;
            end
            if (held_q[i] && tick10 && poll_t_q[i] == 34'h000000001) begin
                held_d[i] = 1'b0;
                drop_d[i] = 1'b1;
            end
            if (poll_req && poll_child == CW'(i)) begin
                poll_t_d[i]  = poll_calc;
                buf_lim_d[i] = buf_calc;
                if (held_q[i]) begin
                    held_d[i] = 1'b0;
                    rel_d[i]  = 1'b1;
                    drop_d[i] = 1'b0;
                end
            end
            // arrival holds, set wins over clear
            if (pkt_arrive && pkt_child == CW'(i)) begin
                held_d[i]  = 1'b1;
                buf_t_d[i] = buf_lim_q[i];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CHILDREN; i++) begin
                buf_t_q[i]   <= '0;
                buf_lim_q[i] <= sleepy_pkg::BUF_MIN;
                poll_t_q[i]  <= '0;
            end
            held_q      <= '0;
            pkt_release <= '0;
            pkt_drop    <= '0;
        end else begin
            buf_t_q     <= buf_t_d;
            buf_lim_q   <= buf_lim_d;
            poll_t_q    <= poll_t_d;
            held_q      <= held_d;
            pkt_release <= rel_d;
            pkt_drop    <= drop_d;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CHILDREN; i++) begin
            child_alive[i] = (poll_t_q[i] != '0);
        end
    end
    assign held = held_q;

    ////////////////////////////////////////////////////////////////////////
    // acknowledgement timeout and retries
    sleepy_pkg::tx_state_e tx_st_q;
    sleepy_pkg::tx_state_e tx_st_d;
    logic [23:0]           ack_t_q;
    logic [23:0]           ack_t_d;
    logic [23:0]           ack_lim_q;
    logic [23:0]           ack_lim_d;
    logic [1:0]            tries_q;
    logic [1:0]            tries_d;
    logic                  send_d;
    logic                  done_d;
    logic                  fail_d;

    always_comb begin
        tx_st_d   = tx_st_q;
        ack_t_d   = ack_t_q;
        ack_lim_d = ack_lim_q;
        tries_d   = tries_q;
        send_d    = 1'b0;
        done_d    = 1'b0;
        fail_d    = 1'b0;
        case (tx_st_q)
            sleepy_pkg::TX_IDLE: begin
                if (tx_start) begin
                    tx_st_d   = sleepy_pkg::TX_WAIT;
                    ack_t_d   = ack_calc;
                    ack_lim_d = ack_calc;
                    tries_d   = 2'h1;
                    send_d    = 1'b1;
                end
            end
            sleepy_pkg::TX_WAIT: begin
                if (ack_rcvd) begin
                    tx_st_d = sleepy_pkg::TX_IDLE;
                    done_d  = 1'b1;
                end else if (ms_tick) begin
                    if (ack_t_q > 24'h000001) begin
                        ack_t_d = ack_t_q - 24'h000001;
                    end else if (tries_q == sleepy_pkg::MAX_TRIES) begin
                        tx_st_d = sleepy_pkg::TX_IDLE;
                        fail_d  = 1'b1;
                    end else begin
                        ack_t_d = ack_lim_q;
                        tries_d = tries_q + 2'h1;
                        send_d  = 1'b1;
                    end
                end
            end
            default: tx_st_d = sleepy_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_st_q   <= sleepy_pkg::TX_IDLE;
            ack_t_q   <= '0;
            ack_lim_q <= '0;
            tries_q   <= '0;
            tx_send   <= 1'b0;
            tx_done   <= 1'b0;
            tx_fail   <= 1'b0;
        end else begin
            tx_st_q   <= tx_st_d;
            ack_t_q   <= ack_t_d;
            ack_lim_q <= ack_lim_d;
            tries_q   <= tries_d;
            tx_send   <= send_d;
            tx_done   <= done_d;
            tx_fail   <= fail_d;
        end
    end
    assign tx_busy = (tx_st_q == sleepy_pkg::TX_WAIT);

    ////////////////////////////////////////////////////////////////////////
    // end-device sleep cadence and sampling
    logic                   pin_s1_q;
    logic                   pin_s2_q;
    logic                   cyclic;
    logic                   pin_hit;
    logic                   samp_en;
    sleepy_pkg::dev_state_e dev_q;
    sleepy_pkg::dev_state_e dev_d;
    logic [15:0]            slp_q;
    logic [15:0]            slp_d;
    logic [15:0]            cyc_q;
    logic [15:0]            cyc_d;
    logic [15:0]            wk_q;
    logic [15:0]            wk_d;
    logic [15:0]            smp_q;
    logic [15:0]            smp_d;
    logic                   ind_q;
    logic                   ind_d;
    logic                   spulse_d;
    logic [2:0]             cfg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= pin_wake_n;
            pin_s2_q <= pin_s1_q;
        end
    end

    always_comb begin
        cyclic  = (sleep_select == sleepy_pkg::SLEEP_CYCLIC)
               || (sleep_select == sleepy_pkg::SLEEP_CYCLIC_PIN);
        pin_hit = (sleep_select == sleepy_pkg::SLEEP_CYCLIC_PIN) && !pin_s2_q;
        samp_en = 1'b0;
        cfg     = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            cfg = line_config[3*i +: 3];
            if (cfg == sleepy_pkg::LINE_DIN || cfg == sleepy_pkg::LINE_DOUT_LO
                || cfg == sleepy_pkg::LINE_DOUT_HI
                || (cfg == sleepy_pkg::LINE_ADC && i < sleepy_pkg::ADC_LINES)) begin
                samp_en = 1'b1;
            end
        end
        samp_en = samp_en && (sample_interval != '0);
    end

    always_comb begin
        dev_d    = dev_q;
        slp_d    = slp_q;
        cyc_d    = cyc_q;
        wk_d     = wk_q;
        smp_d    = smp_q;
        ind_d    = ind_q;
        spulse_d = 1'b0;
        case (dev_q)
            sleepy_pkg::DEV_OFF: begin
                ind_d = 1'b0;
                if (cyclic) begin
                    dev_d = sleepy_pkg::DEV_SLEEP;
                    slp_d = sleep_period;
                end
            end
            sleepy_pkg::DEV_SLEEP: begin
                if (!cyclic) begin
                    dev_d = sleepy_pkg::DEV_OFF;
                // sleep counted in 10 ms ticks
                end else if ((tick10 && slp_q <= 16'h0001) || pin_hit) begin
                    dev_d    = sleepy_pkg::DEV_AWAKE;
                    wk_d     = wake_time;
                    smp_d    = sample_interval;
                    spulse_d = samp_en;
                    if (cyc_q + 16'h0001 >= sleep_cycle_count) begin
                        ind_d = 1'b1;
                        cyc_d = '0;
                    end else begin
                        cyc_d = cyc_q + 16'h0001;
                    end
                end else if (tick10) begin
                    slp_d = slp_q - 16'h0001;
                end
            end
            sleepy_pkg::DEV_AWAKE: begin
                if (!cyclic) begin
                    dev_d = sleepy_pkg::DEV_OFF;
                end else if (ms_tick) begin
                    // wake timer ends the awake time
                    if (wk_q <= 16'h0001) begin
                        dev_d = sleepy_pkg::DEV_SLEEP;
                        slp_d = sleep_period;
                        ind_d = 1'b0;
                    end else begin
                        wk_d = wk_q - 16'h0001;
                        if (samp_en && smp_q <= 16'h0001) begin
                            spulse_d = 1'b1;
                            smp_d    = sample_interval;
                        end else if (smp_q != '0) begin
                            smp_d = smp_q - 16'h0001;
                        end
                    end
                end
            end
            default: dev_d = sleepy_pkg::DEV_OFF;
        endcase
        if (rf_data_rx && dev_d != sleepy_pkg::DEV_OFF) begin
            ind_d = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dev_q         <= sleepy_pkg::DEV_OFF;
            slp_q         <= '0;
            cyc_q         <= '0;
            wk_q          <= '0;
            smp_q         <= '0;
            ind_q         <= 1'b0;
            sample_strobe <= 1'b0;
        end else begin
            dev_q         <= dev_d;
            slp_q         <= slp_d;
            cyc_q         <= cyc_d;
            wk_q          <= wk_d;
            smp_q         <= smp_d;
            ind_q         <= ind_d;
            sample_strobe <= spulse_d;
        end
    end
    assign on_indicator = ind_q;
    assign dev_awake    = (dev_q == sleepy_pkg::DEV_AWAKE);

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_release_poll: assert property (poll_req && held_q[poll_child] |=> pkt_release != '0)
        else $error("held packet not released on poll");
    chk_buf_clamp: assert property (buf_calc >= sleepy_pkg::BUF_MIN && buf_calc <= sleepy_pkg::BUF_MAX)
        else $error("buffer timeout outside clamp");
    chk_poll_reload: assert property (poll_req |=> poll_t_q[$past(poll_child)] == $past(poll_calc))
        else $error("poll timer not reloaded");
    chk_poll_floor: assert property (poll_calc >= sleepy_pkg::POLL_MIN)
        else $error("poll timeout below floor");
    chk_drop_timed: assert property (pkt_drop != '0 |-> $past(tick10))
        else $error("drop without time base tick");
    chk_router_ack: assert property (!tx_to_end_device |-> ack_calc == sleepy_pkg::ACK_HOP_MS * 24'(max_unicast_hops))
        else $error("router ack timeout wrong");
    chk_ack_load: assert property (tx_start && !tx_busy |=> tx_send && ack_t_q == $past(ack_calc))
        else $error("ack timer not loaded");
    chk_retry_limit: assert property (tx_fail |-> $past(tries_q) == sleepy_pkg::MAX_TRIES)
        else $error("failed before all attempts");
    chk_rx_indicate: assert property (rf_data_rx && dev_awake && cyclic |=> on_indicator)
        else $error("radio data did not indicate");
    chk_wake_cyclic: assert property ($rose(dev_awake) |-> $past(cyclic))
        else $error("woke outside cyclic mode");
    chk_sample_gate: assert property (sample_strobe |-> $past(samp_en))
        else $error("sample without enabled line");

    cov_release: cover property (poll_req ##1 pkt_release != '0);
    cov_retry_fail: cover property (tx_send ##[1:1000] tx_send ##[1:1000] tx_fail);
    cov_awake_sample: cover property ($rose(dev_awake) ##[1:1000] sample_strobe);
endmodule

// ==== tb/child_poller.sv ====
// sleeping child model: one poll strobe per bench request
// assumes the parent samples poll_req on the rising clock edge
`timescale 1ns/1ps
module child_poller (
    // clock
    input  wire logic       clock,
    // bench command
    input  wire logic       go,
    input  wire logic [1:0] who,
    // poll strobe to parent
    output logic            poll_req,
    output logic [1:0]      poll_child
);
    initial begin
        poll_req   = 1'b0;
        poll_child = 2'h0;
    end
    always @(posedge clock) begin
        poll_req   <= go;
        poll_child <= go ? who : ~poll_child;
    end
endmodule

// ==== tb/sleepy_child_timeouts_tb.sv ====
// bench for sleepy_child_timeouts: ack table, then parent and sleep cases
// assumes MS_CYCLES of 10, so one ms is ten clocks
`timescale 1ns/1ps
module sleepy_child_timeouts_tb;
    logic        clock, rst, pkt_arrive, tx_start, tx_to_end_device, ack_rcvd, pin_wake_n, rf_data_rx, go;
    logic [15:0] sleep_period, sleep_cycle_count, wake_time, sample_interval;
    logic [7:0]  max_unicast_hops;
    logic [2:0]  sleep_select;
    logic [44:0] line_config;
    logic [1:0]  pkt_child, who, poll_child;
    logic [3:0]  held, child_alive, pkt_release, pkt_drop;
    logic        poll_req, tx_busy, tx_send, tx_done, tx_fail, dev_awake, on_indicator, sample_strobe;
    bit          p_awk, p_ind;
    int          n_fail, checked, cyc, n_send, n_smp, n_wk, n_ind, t0, k, d;
    // ack rows: to end device, hops, ack, sends, ms per try
    bit          r_ed[4]  = '{0, 0, 1, 1};
    int          r_hop[4] = '{1, 2, 1, 1};
    bit          r_ack[4] = '{0, 0, 0, 1};
    int          r_n[4]   = '{3, 3, 3, 1};
    int          r_ms[4]  = '{50, 100, 186, 0};

    sleepy_child_timeouts #(.MS_CYCLES(10)) DUT (
        .clock(clock), .rst(rst), .sleep_period(sleep_period), .sleep_cycle_count(sleep_cycle_count),
        .max_unicast_hops(max_unicast_hops), .wake_time(wake_time), .sample_interval(sample_interval),
        .sleep_select(sleep_select), .line_config(line_config), .pkt_arrive(pkt_arrive), .pkt_child(pkt_child),
        .poll_req(poll_req), .poll_child(poll_child), .held(held), .child_alive(child_alive),
        .pkt_release(pkt_release), .pkt_drop(pkt_drop), .tx_start(tx_start), .tx_to_end_device(tx_to_end_device),
        .ack_rcvd(ack_rcvd), .tx_busy(tx_busy), .tx_send(tx_send), .tx_done(tx_done), .tx_fail(tx_fail),
        .pin_wake_n(pin_wake_n), .rf_data_rx(rf_data_rx), .dev_awake(dev_awake), .on_indicator(on_indicator),
        .sample_strobe(sample_strobe));
    child_poller CHILD (.clock(clock), .go(go), .who(who), .poll_req(poll_req), .poll_child(poll_child));

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cyc    <= cyc + 1;
        n_send <= n_send + int'(tx_send);
        n_smp  <= n_smp + int'(sample_strobe);
        n_wk   <= n_wk + int'(dev_awake && !p_awk);
        n_ind  <= n_ind + int'(on_indicator && !p_ind);
        p_awk  <= dev_awake;
        p_ind  <= on_indicator;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %0h got %0h", nm, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (50000) @(posedge clock);
        n_fail++;
        close_out;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, pkt_arrive, tx_start, tx_to_end_device, ack_rcvd, rf_data_rx, go} = '0;
        {pkt_child, who, sleep_select, line_config} = '0;
        pin_wake_n = 1'b1;
        sleep_period = 16'h0001;
        sleep_cycle_count = 16'h0003;
        wake_time = 16'h0005;
        sample_interval = 16'h0002;
        max_unicast_hops = 8'h01;
        rst = 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk("reset", {held, child_alive, tx_busy, dev_awake, on_indicator}, 0);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            tx_to_end_device <= r_ed[i];
            max_unicast_hops <= 8'(r_hop[i]);
            tx_start <= 1'b1;
            @(posedge clock);
            tx_start <= 1'b0;
            t0 = cyc;
            k = n_send;
            if (r_ack[i]) begin
                repeat (3) @(posedge clock);
                ack_rcvd <= 1'b1;
                @(posedge clock);
                ack_rcvd <= 1'b0;
            end
            for (int j = 0; j < 9000 && !(tx_done || tx_fail); j++) @(negedge clock);
            d = (cyc - t0) / 10;
            chk("sends", n_send - k, r_n[i]);
            chk("fail", tx_fail, !r_ack[i]);
            if (!r_ack[i]) chk("span", 32'(d >= 3 * r_ms[i] - 3 && d <= 3 * r_ms[i] + 1), 1);
            $display("ack row %0d done", i);
        end
        @(posedge clock);
        pkt_arrive <= 1'b1;
        @(posedge clock);
        pkt_arrive <= 1'b0;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(negedge clock);
        chk("held", held[0], 1);
        @(negedge clock);
        chk("release", {pkt_release[0], held[0]}, 2);
        @(posedge clock);
        who <= 2'h2;
        go <= 1'b1;
        pkt_child <= 2'h1;
        pkt_arrive <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        pkt_arrive <= 1'b0;
        t0 = cyc;
        for (int j = 0; j < 13000 && !pkt_drop[1]; j++) @(negedge clock);
        d = (cyc - t0) / 100;
        chk("drop time", 32'(d >= 118 && d <= 121), 1);
        chk("alive", child_alive[3:2], 1);
        $display("parent test done");
        @(posedge clock);
        line_config <= 45'h18;
        for (int s = 4; s < 6; s++) begin
            sleep_select <= 3'(s);
            k = n_smp;
            t0 = n_wk;
            d = n_ind;
            repeat (1500) @(posedge clock);
            chk("samples", 32'(n_smp - k >= n_wk - t0 && n_wk > t0), 1);
            chk("indication", 32'((n_ind - d) * 3 >= n_wk - t0 - 3 && (n_ind - d) * 3 <= n_wk - t0 + 3), 1);
        end
        line_config <= '0;
        sleep_select <= 3'h4;
        repeat (2) @(posedge clock);
        k = n_smp;
        repeat (1000) @(posedge clock);
        chk("no samples", n_smp - k, 0);
        rf_data_rx <= 1'b1;
        @(posedge clock);
        rf_data_rx <= 1'b0;
        @(negedge clock);
        chk("rf indication", on_indicator, 1);
        $display("sleep test done");
        @(posedge clock);
        sleep_period <= 16'h0100;
        repeat (300) @(posedge clock);
        pin_wake_n <= 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk("pin ignored", dev_awake, 0);
        @(posedge clock);
        sleep_select <= 3'h5;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk("pin wake", dev_awake, 1);
        @(posedge clock);
        pin_wake_n <= 1'b1;
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk("mid reset", {held, child_alive, tx_busy, dev_awake, on_indicator}, 0);
        $display("pin and reset test done");
        close_out;
    end
endmodule
